// ===== src/uar_pkg.sv
/*
 * Shared constants and types for the UART receive address filter.
 * Assumes the receiver core hands over complete 9-bit frames.
 */
package uar_pkg;

	// ----------------------------------------------------------------
	// Frame modes of the serial port
	// ----------------------------------------------------------------
	localparam logic [1:0] UAR_MODE_SHIFT = 2'h0; // Shift-register mode
	localparam logic [1:0] UAR_MODE_8VAR  = 2'h1; // 8-bit variable rate
	localparam logic [1:0] UAR_MODE_9FIX  = 2'h2; // 9-bit fixed rate
	localparam logic [1:0] UAR_MODE_9VAR  = 2'h3; // 9-bit variable rate

	// ----------------------------------------------------------------
	// Reset values and sizes
	// ----------------------------------------------------------------
	localparam logic [7:0] UAR_ADDR_RESET = 8'h00;
	localparam logic [7:0] UAR_MASK_RESET = 8'h00;
	localparam int         UAR_FIFO_DEPTH = 32;

	// Received frame: eight data bits plus the ninth bit
	typedef struct packed {
		logic       ninth;
		logic [7:0] data;
	} uar_frame_t;

	localparam int UAR_FRAME_W = $bits(uar_frame_t);

endpackage

// ===== src/uar_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none

module uar_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	output logic                  o_out_valid,
	output logic      [WIDTH-1:0] o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	// Full and empty come from the count flop, never from the inputs
	assign o_in_ready  = (count != (AW+1)'(DEPTH));
	assign o_out_valid = (count != '0);
	assign o_out_data  = mem[rd_ptr];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	// No reset on the array: contents are only read once written
	always_ff @(posedge i_clk)
	begin
		if (push)
			mem[wr_ptr] <= i_in_data;
	end

	// Pointers wrap at DEPTH, which need not be a power of two
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
		end
	end

	// Occupancy
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			count <= '0;
		else if (push && !pop)
			count <= count + 1'b1;
		else if (pop && !push)
			count <= count - 1'b1;
	end

endmodule
`default_nettype wire

// ===== src/uar_addr_filter.sv
/*
 * Receive address filter for the 9-bit UART modes, with a FIFO that
 * holds the frames that pass. Assumes the receiver core presents each
 * frame as a one-cycle valid with data and ninth bit already sampled,
 * and holds it off while o_frame_ready is low.
 */
//
// Summary of operation
// - Compare addresses only while filter enable set; the hit flags still update on every frame taken, enable or not
// - 9-bit modes: flag only on given/broadcast match
// - Ninth bit one marks an address byte
// - Given compare uses only mask-one positions
// - Broadcast is own OR mask, zeros don't-care
// - Reset clears own address and mask
// - C0/FD example: C0/C2 accepted, C1/C3 rejected, FD/FF pass as broadcast
// - Ninth bit kept in readable flag
// - Enable ignored in shift mode, zero in 8-bit
`timescale 1ns/10ps
`default_nettype none

module uar_addr_filter
	import uar_pkg::*;
#(
	parameter int DEPTH = UAR_FIFO_DEPTH
) (
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	input  wire logic [1:0] i_mode,
	input  wire logic       i_multiproc_filter_enable,
	input  wire logic       i_addr_write,
	input  wire logic [7:0] i_own_station_address,
	input  wire logic [7:0] i_station_address_mask,
	input  wire logic       i_frame_valid,
	input  wire uar_frame_t i_frame,
	output logic            o_frame_ready,
	input  wire logic       i_receive_flag_clear,
	output logic            o_receive_flag,
	output logic            o_received_ninth_bit,
	output logic            o_given_hit,
	output logic            o_broadcast_hit,
	output logic            o_rd_valid,
	output uar_frame_t      o_rd_frame,
	input  wire logic       i_rd_ready
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// True when value equals ref on every position where care is one
	function automatic logic masked_eq(input logic [7:0] value,
	                                   input logic [7:0] ref_val,
	                                   input logic [7:0] care);
		masked_eq = (((value ^ ref_val) & care) == 8'h00);
	endfunction

	logic [7:0]      own_station_address;
	logic [7:0]      station_address_mask;
	logic [7:0]      broadcast;
	logic            nine_bit_mode;
	logic            filtering;
	logic            given_match;
	logic            bcast_match;
	logic            accept;
	logic            take;
	logic            push;
	logic            fifo_in_ready;
	logic [UAR_FRAME_W-1:0] fifo_out;

	// ----------------------------------------------------------------
	// Address registers
	// ----------------------------------------------------------------
	// Zero after reset makes every bit don't-care, so all addresses pass
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			own_station_address  <= UAR_ADDR_RESET;
			station_address_mask <= UAR_MASK_RESET;
		end
		else if (i_addr_write)
		begin
			own_station_address  <= i_own_station_address;
			station_address_mask <= i_station_address_mask;
		end
	end

	// ----------------------------------------------------------------
	// Match decision
	// ----------------------------------------------------------------
	// Enable has no effect outside the 9-bit modes; software keeps it
	// low in the 8-bit mode, so both non-9-bit modes simply bypass.
	assign nine_bit_mode = (i_mode == UAR_MODE_9FIX) ||
	                       (i_mode == UAR_MODE_9VAR);
	assign filtering     = nine_bit_mode & i_multiproc_filter_enable;
	assign broadcast     = own_station_address | station_address_mask;
	assign given_match   = masked_eq(i_frame.data, own_station_address,
	                                 station_address_mask);
	assign bcast_match   = masked_eq(i_frame.data, broadcast, broadcast);

	// Frame arrives with its ninth bit already sampled, so the compare
	// runs on complete data; data bytes never pass while filtering
	assign accept = !filtering ||
	                (i_frame.ninth && (given_match || bcast_match));
	assign take   = i_frame_valid & o_frame_ready;
	assign push   = take & accept;

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	// A new frame in the cycle of a clear keeps the flag set
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			o_receive_flag <= 1'b0;
		else if (push)
			o_receive_flag <= 1'b1;
		else if (i_receive_flag_clear)
			o_receive_flag <= 1'b0;
	end

	// Ninth bit is only meaningful in the 9-bit modes
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			o_received_ninth_bit <= 1'b0;
		else if (push && nine_bit_mode)
			o_received_ninth_bit <= i_frame.ninth;
	end

	// Match results of the last frame, for software diagnosis
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_given_hit     <= 1'b0;
			o_broadcast_hit <= 1'b0;
		end
		else if (take)
		begin
			o_given_hit     <= i_frame.ninth & given_match;
			o_broadcast_hit <= i_frame.ninth & bcast_match;
		end
	end

	// ----------------------------------------------------------------
	// Frame buffer
	// ----------------------------------------------------------------
	// Ready stalls the receiver core when software falls behind
	uar_fifo #(
		.WIDTH (UAR_FRAME_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.i_clk       (i_clk),
		.i_reset     (i_reset),
		.i_in_valid  (push),
		.i_in_data   (i_frame),
		.o_in_ready  (fifo_in_ready),
		.o_out_valid (o_rd_valid),
		.o_out_data  (fifo_out),
		.i_out_ready (i_rd_ready)
	);

	assign o_frame_ready = fifo_in_ready;
	assign o_rd_frame    = uar_frame_t'(fifo_out);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_enable_gates: assert property (@(posedge i_clk) disable iff (i_reset)
		take && !i_multiproc_filter_enable && !i_frame.ninth |=> o_receive_flag)
		else $error("frame lost with filtering off");

	chk_flag_on_match: assert property (@(posedge i_clk) disable iff (i_reset)
		take && filtering && i_frame.ninth && (given_match || bcast_match)
		|=> o_receive_flag && $past(o_rd_valid || push))
		else $error("matching address did not raise flag");

	chk_data_suppressed: assert property (@(posedge i_clk) disable iff (i_reset)
		take && filtering && !i_frame.ninth |-> !push)
		else $error("data byte passed while filtering");

	chk_given_compare: assert property (@(posedge i_clk) disable iff (i_reset)
		given_match == (&(~station_address_mask |
		                ~(i_frame.data ^ own_station_address))))
		else $error("given compare wrong");

	chk_broadcast_form: assert property (@(posedge i_clk) disable iff (i_reset)
		bcast_match == (&(~(own_station_address | station_address_mask) |
		                i_frame.data)))
		else $error("broadcast compare wrong");

	chk_reset_clears: assert property (@(posedge i_clk)
		$past(i_reset) |-> own_station_address == 8'h00 &&
		station_address_mask == 8'h00 && !o_receive_flag)
		else $error("address or mask not cleared by reset");

	chk_example_slave: assert property (@(posedge i_clk) disable iff (i_reset)
		take && filtering && i_frame.ninth && own_station_address == 8'hC0 &&
		station_address_mask == 8'hFD && i_frame.data[7:2] == 6'h30
		|-> push == !i_frame.data[0])
		else $error("example address decision wrong");

	chk_ninth_stored: assert property (@(posedge i_clk) disable iff (i_reset)
		push && nine_bit_mode |=> o_received_ninth_bit == $past(i_frame.ninth))
		else $error("ninth bit not stored");

	chk_shift_bypass: assert property (@(posedge i_clk) disable iff (i_reset)
		take && i_mode == UAR_MODE_SHIFT |-> push)
		else $error("shift mode frame filtered");

	chk_set_wins: assert property (@(posedge i_clk) disable iff (i_reset)
		push && i_receive_flag_clear |=> o_receive_flag ##1
		(o_receive_flag || $past(i_receive_flag_clear)))
		else $error("flag lost against clear");

	chk_clear_drops: assert property (@(posedge i_clk) disable iff (i_reset)
		i_receive_flag_clear && !push |=> !o_receive_flag)
		else $error("flag not cleared");

	chk_data_no_hit: assert property (@(posedge i_clk) disable iff (i_reset)
		take && !i_frame.ninth |=> !o_given_hit && !o_broadcast_hit)
		else $error("data byte reported as address hit");

endmodule
`default_nettype wire

// ===== tb/uar_master_model.sv
/*
 * Master UART model: presents 9-bit frames to the address filter.
 * Assumes the bench calls send() from one process at a time.
 */
`timescale 1ns/10ps
`default_nettype none

module uar_master_model
	import uar_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_ready,
	output logic      o_valid,
	output uar_frame_t o_frame
);
	initial
	begin
		o_valid = 1'b0;
		o_frame = 9'h000;
	end

	// Hold the frame until taken, then show its inverse so stale data
	// can never pass for a fresh frame
	task automatic send(input logic n, input logic [7:0] d);
		@(posedge i_clk);
		o_valid <= 1'b1;
		o_frame <= {n, d};
		do @(negedge i_clk); while (i_ready !== 1'b1);
		@(posedge i_clk);
		o_valid <= 1'b0;
		o_frame <= ~{n, d};
	endtask
endmodule

`default_nettype wire

// ===== tb/uar_addr_filter_tb_top.sv
/*
 * Self-checking bench for the receive address filter and its FIFO.
 * Assumes a master model on the frame input and a small FIFO depth.
 */
`timescale 1ns/10ps
`default_nettype none

module uar_addr_filter_tb_top
	import uar_pkg::*;
;
	localparam int DEPTH = 4;
	logic       clk = 1'b0, reset = 1'b1, addr_write = 1'b0;
	logic       filt_en = 1'b0, clear = 1'b0, rd_ready = 1'b0;
	logic       valid, frame_ready, flag, ninth, given, bcast, rd_valid;
	logic [1:0] mode = 2'h2;
	logic [7:0] own = 8'h00, mask = 8'h00;
	uar_frame_t frame, rd_frame;
	int         failures = 0, check_count = 0, cycles = 0;

	always #2.5 clk = ~clk;

	uar_addr_filter #(.DEPTH(DEPTH)) uar_addr_filter_i (
		.i_clk(clk), .i_reset(reset), .i_mode(mode),
		.i_multiproc_filter_enable(filt_en), .i_addr_write(addr_write),
		.i_own_station_address(own), .i_station_address_mask(mask),
		.i_frame_valid(valid), .i_frame(frame), .o_frame_ready(frame_ready),
		.i_receive_flag_clear(clear), .o_receive_flag(flag),
		.o_received_ninth_bit(ninth), .o_given_hit(given),
		.o_broadcast_hit(bcast), .o_rd_valid(rd_valid),
		.o_rd_frame(rd_frame), .i_rd_ready(rd_ready));

	uar_master_model uar_master_model_i (
		.i_clk(clk), .i_ready(frame_ready), .o_valid(valid), .o_frame(frame));

	// ----------------------------------------------------------------
	// Reporting
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check_bit(input logic a, input logic e, input string w);
		check_count++;
		if (a !== e)
		begin
			failures++;
			$display("Error at %0t: %s wrong", $time, w);
		end
	endtask

	task automatic check_frame(input uar_frame_t a, input uar_frame_t e);
		check_count++;
		if (a !== e)
		begin
			failures++;
			$display("Error at %0t: frame %h not %h", $time, a, e);
		end
	endtask

	// Cut a hang short; the whole run needs well under this
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// Drivers
	// ----------------------------------------------------------------
	task automatic do_reset();
		@(posedge clk);
		reset <= 1'b1;
		own   <= 8'h00; // Bench copy follows the cleared state
		mask  <= 8'h00;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
	endtask

	task automatic set_addr(input logic [7:0] o, input logic [7:0] m);
		@(posedge clk);
		own        <= o;
		mask       <= m;
		addr_write <= 1'b1;
		@(posedge clk);
		addr_write <= 1'b0;
	endtask

	// Send one frame, judge flag, FIFO, ninth bit and (while filtering) hits, then clear the flag and pop
	task automatic run_one(input logic [1:0] m, input logic en,
	                       input logic n, input logic [7:0] d);
		logic g, b, acc;
		g   = ((d ^ own) & mask) == 8'h00;
		b   = (d & (own | mask)) == (own | mask);
		acc = !(m[1] && en) || (n && (g || b));
		@(posedge clk);
		mode    <= m;
		filt_en <= en;
		uar_master_model_i.send(n, d);
		@(negedge clk);
		check_bit(flag, acc, "flag");
		check_bit(rd_valid, acc, "fifo");
		if (m[1] && en)
		begin
			check_bit(given, n && g, "given");
			check_bit(bcast, n && b, "bcast");
		end
		if (acc && m[1])
			check_bit(ninth, n, "ninth");
		if (acc)
			check_frame(rd_frame, {n, d});
		@(posedge clk);
		clear    <= 1'b1;
		rd_ready <= 1'b1;
		@(posedge clk);
		clear    <= 1'b0;
		rd_ready <= 1'b0;
	endtask

	task automatic pop(input int i);
		@(negedge clk);
		for (int k = 0; k < 20 && rd_valid !== 1'b1; k++) @(negedge clk);
		check_frame(rd_frame, {1'b0, 8'h10 + 8'(i)});
		@(posedge clk);
		rd_ready <= 1'b1;
		@(posedge clk);
		rd_ready <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_state();
		@(negedge clk);
		check_bit(flag, 1'b0, "reset flag");
		check_bit(frame_ready, 1'b1, "reset ready");
		check_bit(rd_valid | given | bcast, 1'b0, "reset out");
		run_one(2'h2, 1'b1, 1'b1, 8'h5A);
	endtask

	// Bit 1 is ignored, bit 0 must be zero except broadcast FD/FF, data bytes are dropped
	task automatic t_example();
		logic [8:0] tbl[7] = '{9'h1C0, 9'h1C2, 9'h1C1, 9'h1C3,
		                       9'h1FD, 9'h1FF, 9'h0C0};
		set_addr(8'hC0, 8'hFD);
		foreach (tbl[i]) run_one(2'h2, 1'b1, tbl[i][8], tbl[i][7:0]);
	endtask

	task automatic t_modes();
		run_one(2'h0, 1'b1, 1'b0, 8'h33);
		run_one(2'h1, 1'b0, 1'b0, 8'h34);
		run_one(2'h3, 1'b1, 1'b1, 8'hC2);
		run_one(2'h3, 1'b1, 1'b1, 8'h12);
		run_one(2'h3, 1'b0, 1'b0, 8'h12);
		run_one(2'h2, 1'b0, 1'b1, 8'h12);
	endtask

	// Fill until refused with the reader stalled, then drain in order
	task automatic t_fifo();
		for (int i = 0; i < DEPTH; i++)
			uar_master_model_i.send(1'b0, 8'h10 + 8'(i));
		@(negedge clk);
		check_bit(frame_ready, 1'b0, "full");
		fork
			uar_master_model_i.send(1'b0, 8'h10 + 8'(DEPTH));
			for (int i = 0; i <= DEPTH; i++) pop(i);
		join
		@(negedge clk);
		check_bit(rd_valid, 1'b0, "empty");
		// A frame taken in the cycle of a clear must leave the flag set
		fork
			uar_master_model_i.send(1'b0, 8'h66);
			begin
				@(posedge clk);
				clear <= 1'b1;
				@(posedge clk);
				clear <= 1'b0;
			end
		join
		@(negedge clk);
		check_bit(flag, 1'b1, "set against clear");
		check_frame(rd_frame, {1'b0, 8'h66});
		// Leave the flag low and the buffer empty for the next scenario
		@(posedge clk);
		clear    <= 1'b1;
		rd_ready <= 1'b1;
		@(posedge clk);
		clear    <= 1'b0;
		rd_ready <= 1'b0;
		@(negedge clk);
		check_bit(flag | rd_valid, 1'b0, "clear and pop");
	endtask

	task automatic t_reset_addr();
		set_addr(8'hC0, 8'hFD);
		run_one(2'h2, 1'b1, 1'b1, 8'h00);
		do_reset();
		run_one(2'h2, 1'b1, 1'b1, 8'h00);
	endtask

	initial
	begin
		do_reset();
		t_reset_state();
		t_example();
		t_modes();
		t_fifo();
		t_reset_addr();
		wrap_up();
	end
endmodule

`default_nettype wire
